// [design/bsr_pkg.sv]
// Shared types and constants for the four-stage bidirectional shift register.
// Assumes one system clock; every pin of the register arrives from outside it.
`default_nettype none
package bsr_pkg;
    localparam int BSR_STAGES = 4;
    localparam int BSR_FIFO_DEPTH = 16;
    localparam int BSR_SYNC_DEPTH = 2;
    localparam logic BSR_MODE_LOAD = 1'h1;
    localparam logic BSR_LOW = 1'h0;

    // One sampled clock edge: mode, serial bit and the parallel word.
    typedef struct packed {
        logic mode;
        logic serial;
        logic [BSR_STAGES-1:0] par;
    } bsr_cmd_s;

    // Every pin level that crosses into the system clock domain.
    typedef struct packed {
        logic shift_clk;
        logic out_ctrl;
        bsr_cmd_s cmd;
    } bsr_pin_s;

    // State of the register top, apart from the edge FIFO.
    typedef struct packed {
        bsr_pin_s sync1;
        bsr_pin_s sync2;
        logic clk_prev;
        logic [BSR_STAGES-1:0] stage;
        logic valid;
        logic drive;
    } bsr_state_s;
endpackage : bsr_pkg
`default_nettype wire

// [design/bsr_shift_reg.sv]
// Four-stage register with parallel load, shift toward the last stage and three-state taps.
// Assumes the board drives the pins asynchronously; edges of shift_clk are far slower
// than sys_clk so that each low phase spans several system cycles.
`default_nettype none

// Flip-flop FIFO with valid and ready on both sides.
module bsr_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage carries no reset; only the pointers and the count need a defined start.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? AW'(wr_ptr + 1'h1) : wr_ptr;
            rd_ptr <= pop ? AW'(rd_ptr + 1'h1) : rd_ptr;
            count <= (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
        end
    end
endmodule : bsr_fifo

module bsr_shift_reg
    import bsr_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register pins from the board.
    input wire logic shift_clk,
    input wire logic mode,
    input wire logic serial,
    input wire logic [BSR_STAGES-1:0] par,
    input wire logic out_ctrl,
    // Apply-side stall and edge back-pressure.
    input wire logic hold_apply,
    output logic edge_ready,
    // Three-state taps, first stage to last.
    output logic tap_one,
    output logic tap_two,
    output logic tap_three,
    output logic tap_four,
    output logic tap_oe,
    output logic stage_valid
);
    bsr_state_s st;
    bsr_state_s next_st;
    bsr_pin_s pins;
    logic fall;
    logic cmd_valid;
    logic pop;
    bsr_cmd_s cmd;

    assign pins = '{shift_clk: shift_clk, out_ctrl: out_ctrl,
                    cmd: '{mode: mode, serial: serial, par: par}};
    // falling edge detect
    // Only the second synchroniser stage and its delayed copy feed the detector.
    assign fall = st.clk_prev & (st.sync2.shift_clk == BSR_LOW);
    assign pop = cmd_valid & ~hold_apply;

    // Each falling edge queues its sampled levels while the FIFO has room; a stalled apply side lets it fill.
    bsr_fifo #(.WIDTH($bits(bsr_cmd_s)), .DEPTH(BSR_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(fall),
        .in_ready(edge_ready),
        .in_data(st.sync2.cmd),
        .out_valid(cmd_valid),
        .out_ready(pop),
        .out_data(cmd)
    );

    // Next-state logic for synchronisers, stages and tap drive.
    always_comb begin
        next_st = st;
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.clk_prev = st.sync2.shift_clk;
        next_st.drive = st.sync2.out_ctrl;
        if (pop) begin
            next_st.valid = 1'h1;
            if (cmd.mode == BSR_MODE_LOAD) begin
                next_st.stage = cmd.par;
            end else begin
                for (int i = BSR_STAGES - 1; i > 0; i--) begin
                    next_st.stage[i] = st.stage[i-1];
                end
                next_st.stage[0] = cmd.serial;
            end
        end
    end

    // stages not reset
    // Stage contents keep no reset value, matching the part's power-up behaviour.
    always_ff @(posedge sys_clk) begin
        st.stage <= next_st.stage;
        if (reset) begin
            st.sync1 <= '0;
            st.sync2 <= '0;
            st.clk_prev <= 1'h0;
            st.valid <= 1'h0;
            st.drive <= 1'h0;
        end else begin
            st.sync1 <= next_st.sync1;
            st.sync2 <= next_st.sync2;
            st.clk_prev <= next_st.clk_prev;
            st.valid <= next_st.valid;
            st.drive <= next_st.drive;
        end
    end

    // The board resolves the bus from tap_oe; all taps share one enable.
    assign tap_one = st.stage[0];
    assign tap_two = st.stage[1];
    assign tap_three = st.stage[2];
    assign tap_four = st.stage[3];
    assign tap_oe = st.drive;
    assign stage_valid = st.valid;

    sequence s_load;
        pop && cmd.mode == BSR_MODE_LOAD;
    endsequence
    sequence s_shift;
        pop && cmd.mode != BSR_MODE_LOAD;
    endsequence
    sequence s_ctrl_low;
        !out_ctrl [*4];
    endsequence

    property p_load;
        @(posedge sys_clk) disable iff (reset) s_load |=> st.stage == $past(cmd.par);
    endproperty
    a_load: assert property (p_load) else $error("load did not store parallel word");
    // A load whose serial level differs from the first parallel bit shows any leak.
    property p_serial_ignored;
        @(posedge sys_clk) disable iff (reset)
            s_load ##0 (cmd.serial != cmd.par[0]) |=> st.stage[0] != $past(cmd.serial);
    endproperty
    a_serial_ignored: assert property (p_serial_ignored)
        else $error("serial leaked into load");
    property p_shift;
        @(posedge sys_clk) disable iff (reset)
            s_shift |=> st.stage == {$past(st.stage[2:0]), $past(cmd.serial)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift result wrong");
    property p_edge_queued;
        @(posedge sys_clk) disable iff (reset) fall && edge_ready |=> cmd_valid;
    endproperty
    a_edge_queued: assert property (p_edge_queued)
        else $error("falling edge not queued");
    property p_hold;
        @(posedge sys_clk) disable iff (reset) !pop |=> $stable(st.stage);
    endproperty
    a_hold: assert property (p_hold) else $error("stage changed without an edge");
    property p_drive;
        @(posedge sys_clk) disable iff (reset) out_ctrl [*4] |=> tap_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("taps not driven");
    property p_release;
        @(posedge sys_clk) disable iff (reset) s_ctrl_low |=> !tap_oe;
    endproperty
    a_release: assert property (p_release) else $error("taps not released");
    // A shift applied while the taps are released must still move the serial bit in.
    property p_runs_released;
        @(posedge sys_clk) disable iff (reset)
            s_shift ##0 !tap_oe |=> stage_valid && st.stage[0] == $past(cmd.serial);
    endproperty
    a_runs_released: assert property (p_runs_released)
        else $error("stalled while released");
    property p_undefined_until_apply;
        @(posedge sys_clk) disable iff (reset) !stage_valid && !pop |=> !stage_valid;
    endproperty
    a_undefined_until_apply: assert property (p_undefined_until_apply)
        else $error("valid early");
endmodule : bsr_shift_reg
`default_nettype wire

// [tb/bsr_board.sv]
// Board model: feeds the parallel inputs and shares the tap bus lines.
// Assumes taps and enable come straight from the register top.
`default_nettype none
module bsr_board
    import bsr_pkg::*;
(
    // Requests from the bench.
    input wire logic left,
    input wire logic sin,
    input wire logic [BSR_STAGES-1:0] par_req,
    // Register taps.
    input wire logic [BSR_STAGES-1:0] taps,
    input wire logic tap_oe,
    // Board levels.
    output logic [BSR_STAGES-1:0] par,
    output logic [BSR_STAGES-1:0] bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [BSR_STAGES-1:0] last = 4'h0;
    assign par = left ? {sin, taps[3:1]} : par_req;
    // one bus driver
    // Released lines show the inverse of the last level, so stale data never matches.
    assign bus = tap_oe ? taps : ~last;
    always @(taps or tap_oe) begin
        if (tap_oe) last = taps;
    end
endmodule : bsr_board
`default_nettype wire

// [tb/bsr_shift_reg_tb.sv]
// Bench for the shift register: directed, random and queue-full edges.
// Assumes the board model and the design files are compiled first.
`default_nettype none
module bsr_shift_reg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bsr_pkg::*;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic shift_clk = 1'h1;
    logic mode = 1'h0;
    logic serial = 1'h0;
    logic out_ctrl = 1'h0;
    logic hold_apply = 1'h0;
    logic left = 1'h0;
    logic [3:0] par_req = 4'h0;
    logic [3:0] par, bus, taps, exp, prev;
    logic t1, t2, t3, t4, tap_oe, stage_valid, edge_ready;
    int n_errors = 0;
    int n_tests = 0;
    assign taps = {t4, t3, t2, t1};
    always #5 sys_clk = ~sys_clk;
    bsr_shift_reg uut (.sys_clk(sys_clk), .reset(reset), .shift_clk(shift_clk), .mode(mode),
        .serial(serial), .par(par), .out_ctrl(out_ctrl), .hold_apply(hold_apply),
        .edge_ready(edge_ready), .tap_one(t1), .tap_two(t2), .tap_three(t3), .tap_four(t4),
        .tap_oe(tap_oe), .stage_valid(stage_valid));
    bsr_board board (.left(left), .sin(serial), .par_req(par_req), .taps(taps),
        .tap_oe(tap_oe), .par(par), .bus(bus));
    // Expected stage word after one accepted edge.
    function automatic logic [3:0] calc(input logic m, s, l, input logic [3:0] p, c);
        if (l) return {s, c[3:1]};
        return m ? p : {c[2:0], s};
    endfunction : calc
    task automatic chk(input string what, input logic [3:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // One clock pulse; data settles four cycles before the fall.
    task automatic pulse(input logic m, s, l, input logic [3:0] p, input logic oc, tk);
        @(negedge sys_clk);
        mode = l | m;
        serial = s;
        left = l;
        par_req = p;
        out_ctrl = oc;
        if (tk) exp = calc(m, s, l, p, exp);
        repeat (4) @(negedge sys_clk);
        shift_clk = 1'h0;
        repeat (4) @(negedge sys_clk);
        shift_clk = 1'h1;
        repeat (6) @(negedge sys_clk);
    endtask : pulse
    task automatic results;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("watchdog expired");
        results();
    end
    initial begin
        void'($urandom(32'hf2a1));
        exp = 4'h0;
        repeat (2) @(negedge sys_clk);
        reset = 1'h0;
        chk("valid", 4'h0, {3'h0, stage_valid});
        pulse(1'h1, 1'h1, 1'h0, 4'ha, 1'h1, 1'h1);
        chk("load", exp, taps);
        chk("valid", 4'h1, {3'h0, stage_valid});
        pulse(1'h0, 1'h1, 1'h0, 4'h0, 1'h1, 1'h1);
        chk("shift", exp, bus);
        pulse(1'h1, 1'h1, 1'h1, 4'h0, 1'h0, 1'h1);
        chk("left", exp, taps);
        chk("oe", 4'h0, {3'h0, tap_oe});
        $display("directed done");
        for (int i = 0; i < 24; i++) begin
            pulse(1'($urandom), 1'($urandom), 1'($urandom), 4'($urandom), 1'($urandom), 1'h1);
            chk("taps", exp, taps);
            chk("oe", {3'h0, out_ctrl}, {3'h0, tap_oe});
            if (out_ctrl) chk("bus", exp, bus);
        end
        $display("random done");
        hold_apply = 1'h1;
        prev = exp;
        for (int i = 0; i < 18; i++) pulse(1'h0, 1'($urandom), 1'h0, 4'h0, 1'h1, i < 16);
        chk("held", prev, taps);
        chk("full", 4'h0, {3'h0, edge_ready});
        hold_apply = 1'h0;
        repeat (40) @(negedge sys_clk);
        chk("drain", exp, taps);
        chk("ready", 4'h1, {3'h0, edge_ready});
        $display("queue done");
        // Mid-run reset: enable and queue clear, stage contents survive.
        reset = 1'h1;
        repeat (2) @(negedge sys_clk);
        chk("rst oe", 4'h0, {3'h0, tap_oe});
        chk("rst valid", 4'h0, {3'h0, stage_valid});
        chk("rst ready", 4'h1, {3'h0, edge_ready});
        chk("rst taps", exp, taps);
        reset = 1'h0;
        pulse(1'h1, 1'h0, 1'h0, 4'h5, 1'h1, 1'h1);
        chk("reload", exp, taps);
        chk("valid", 4'h1, {3'h0, stage_valid});
        $display("reset done");
        results();
    end
endmodule : bsr_shift_reg_tb
`default_nettype wire
